// ### rtl/adac_top.sv
// audio converter control: registers, queues, divider and two channels
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - two independent channels, left and right
// - each channel queues four 16-bit samples
// - empty queue: use fallback value instead
// - samples accepted as 16-bit words
// - sign_select: 1 signed, 0 unsigned
// - unsigned: 0x8000 is midpoint
// - signed: 0x0000 is midpoint
// - interpolate each channel by 256
// - second-order one-bit delta-sigma modulator
// - converter clock equals input over divisor+1
// - divisor resets to divide by six
// - one sample per 256 converter cycles
// - converter_on switches block on or off
// - idle_halt stops block while system idle
// - amp_keep holds amplifier on when halted by idle or sleep, not when converter_on is clear
// - unimplemented control bits read zero
// - writing sample port pushes into queue
// - full and empty flags readable
// - irq on empty or on not-full
//
module adac_top (
    input  wire logic        clk_i,        // auxiliary oscillator clock
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // system power state
    input  wire logic        sys_idle_i,   // system in idle
    input  wire logic        sys_sleep_i,  // system in sleep
    // converter side
    output logic             left_bit_o,   // left one-bit stream
    output logic             right_bit_o,  // right one-bit stream
    output logic             amp_on_o,     // output amplifier enable
    output logic             left_irq_o,   // left queue request
    output logic             right_irq_o   // right queue request
);
    // ==========================================================
    // register file
    logic [15:0] con, next_con;      // converter_control
    logic [15:0] stat_w, next_stat_w;  // writable part of status
    logic [15:0] dflt, next_dflt;    // fallback_value
    logic [31:0] next_dat;
    logic        next_ack;
    logic [15:0] wdata;              // write data after byte lanes
    logic [15:0] lane_mask;          // lanes selected by sel
    logic        wr_take;            // write takes effect this edge
    logic [15:0] stat_rd;            // assembled status read value

    // control fields
    logic                              converter_on;
    logic                              idle_halt;
    logic                              amp_keep;
    logic                              sign_select;
    logic [adac_pkg::DIV_W-1:0]        clk_divisor;
    logic                              left_irq_kind;
    logic                              right_irq_kind;

    // channel vectors, index 0 left and 1 right
    logic [1:0]  push;               // sample port write
    logic [1:0]  queue_full;
    logic [1:0]  queue_empty;
    logic [1:0]  pop;
    logic [15:0] head [2];
    logic [1:0]  mod_bit;

    // ==========================================================
    // field decode
    assign converter_on   = con[adac_pkg::CON_ON_BIT];
    assign idle_halt      = con[adac_pkg::CON_IDLE_BIT];
    assign amp_keep       = con[adac_pkg::CON_AMP_BIT];
    assign sign_select    = con[adac_pkg::CON_SIGN_BIT];
    assign clk_divisor    = con[adac_pkg::CON_DIV_LSB +: adac_pkg::DIV_W];
    assign left_irq_kind  = stat_w[adac_pkg::STAT_LKIND_BIT];
    assign right_irq_kind = stat_w[adac_pkg::STAT_RKIND_BIT];

    // a write is applied only at the edge where ack is seen high
    assign wr_take   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdata     = wb_dat_i[15:0] & lane_mask;

    // status view: kind bits stored, flags live
    always_comb begin
        stat_rd = stat_w;
        stat_rd[adac_pkg::STAT_LEFT_QUEUE_FULL_BIT]  = queue_full[0];
        stat_rd[adac_pkg::STAT_LEFT_QUEUE_EMPTY_BIT] = queue_empty[0];
        stat_rd[adac_pkg::STAT_RIGHT_QUEUE_FULL_BIT]  = queue_full[1];
        stat_rd[adac_pkg::STAT_RIGHT_QUEUE_EMPTY_BIT] = queue_empty[1];
    end

    // ==========================================================
    // bus slave: next values of registers, ack and read data
    always_comb begin
        next_con    = con;
        next_stat_w = stat_w;
        next_dflt   = dflt;
        push        = 2'b00;
        // ack one cycle after the request, dropped the cycle after
        next_ack    = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat    = wb_dat_o;
        if (next_ack) begin
            // read data is prepared alongside ack; unmapped reads zero
            unique case (wb_adr_i)
                adac_pkg::ADDR_CON:  next_dat = {16'h0000, con};
                adac_pkg::ADDR_STAT: next_dat = {16'h0000, stat_rd};
                adac_pkg::ADDR_DFLT: next_dat = {16'h0000, dflt};
                default:             next_dat = 32'h0000_0000;
            endcase
        end
        if (wr_take) begin
            unique case (wb_adr_i)
                adac_pkg::ADDR_CON: begin
                    // unimplemented bits ignore writes
                    next_con = (con & ~(lane_mask & adac_pkg::CON_WMASK))
                             | (wdata & adac_pkg::CON_WMASK);
                end
                adac_pkg::ADDR_STAT: begin
                    // flags are read only; kind bits steer the irqs
                    next_stat_w = (stat_w & ~(lane_mask & adac_pkg::STAT_WMASK))
                                | (wdata & adac_pkg::STAT_WMASK);
                end
                adac_pkg::ADDR_DFLT: begin
                    next_dflt = (dflt & ~lane_mask) | wdata;
                end
                adac_pkg::ADDR_LDAT: begin
                    push[0] = |wb_sel_i[1:0];
                end
                adac_pkg::ADDR_RDAT: begin
                    push[1] = |wb_sel_i[1:0];
                end
                default: begin
                    // unmapped writes are acknowledged and dropped
                end
            endcase
        end
    end

    // register the bus side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            con      <= adac_pkg::CON_RESET;
            stat_w   <= adac_pkg::STAT_RESET;
            dflt     <= adac_pkg::DFLT_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            con      <= next_con;
            stat_w   <= next_stat_w;
            dflt     <= next_dflt;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ==========================================================
    // run state and converter clock divider
    logic                       running;          // logic advancing
    logic [adac_pkg::DIV_W-1:0] div_cnt, next_div_cnt;
    logic [adac_pkg::OSR_W-1:0] osr_cnt, next_osr_cnt;
    logic                       tick;             // converter clock enable
    logic                       sample_strobe;    // take next samples
    logic                       next_amp;

    // stopped when off, in sleep, or idle with idle_halt set
    assign running = converter_on && !sys_sleep_i
                   && !(idle_halt && sys_idle_i);
    // one tick every divisor+1 input cycles
    assign tick = running && (div_cnt == clk_divisor);
    // a sample is taken on the first tick of each 256
    assign sample_strobe = tick && (osr_cnt == '0);

    // next divider, oversampling count and amplifier state
    always_comb begin
        next_div_cnt = div_cnt;
        next_osr_cnt = osr_cnt;
        if (!converter_on) begin
            // restart cleanly so the first sample is taken at once
            next_div_cnt = '0;
            next_osr_cnt = '0;
        end else if (running) begin
            next_div_cnt = tick ? '0 : div_cnt + 1'b1;
            next_osr_cnt = tick ? osr_cnt + 1'b1 : osr_cnt;
        end
        // when stopped, the amplifier stays only if amp_keep is set
        next_amp = converter_on && (running || amp_keep);
    end

    // register divider state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt  <= '0;
            osr_cnt  <= '0;
            amp_on_o <= 1'b0;
        end else begin
            div_cnt  <= next_div_cnt;
            osr_cnt  <= next_osr_cnt;
            amp_on_o <= next_amp;
        end
    end

    // ==========================================================
    // channels: queue, fallback, format and modulator
    genvar ch;
    generate
        for (ch = 0; ch < adac_pkg::CHANNELS; ch++) begin : g_chan
            logic [15:0]        raw;      // queued or fallback word
            logic signed [15:0] fmt;      // signed sign_select for modulator

            // separate queue per channel
            adac_queue #(
                .WIDTH (adac_pkg::SAMPLE_W),
                .DEPTH (adac_pkg::QUEUE_DEP)
            ) u_queue (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .push_i  (push[ch]),
                .data_i  (wb_dat_i[15:0]),
                .pop_i   (pop[ch]),
                .head_o  (head[ch]),
                .full_o  (queue_full[ch]),
                .empty_o (queue_empty[ch])
            );

            // take the head only when something is queued
            assign pop[ch] = sample_strobe && !queue_empty[ch];
            // empty queue feeds the fallback word
            assign raw = queue_empty[ch] ? dflt : head[ch];
            // unsigned moves midpoint 0x8000 to zero by flipping the msb
            assign fmt = sign_select ? raw : {~raw[15], raw[14:0]};

            adac_mod #(
                .OSR_W (adac_pkg::OSR_W)
            ) u_mod (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .tick_i   (tick),
                .load_i   (sample_strobe),
                .sample_i (fmt),
                .bit_o    (mod_bit[ch])
            );
        end
    endgenerate

    assign left_bit_o  = mod_bit[0];
    assign right_bit_o = mod_bit[1];

    // ==========================================================
    // queue requests, registered so outputs come from flops
    logic next_lirq;
    logic next_rirq;

    // kind 1 asks on empty, kind 0 asks whenever there is room
    always_comb begin
        next_lirq = left_irq_kind ? queue_empty[0] : !queue_full[0];
        next_rirq = right_irq_kind ? queue_empty[1] : !queue_full[1];
    end

    // register requests
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_irq_o  <= 1'b0;
            right_irq_o <= 1'b0;
        end else begin
            left_irq_o  <= next_lirq;
            right_irq_o <= next_rirq;
        end
    end
endmodule
`default_nettype wire

// ### include/adac_pkg.sv
// shared constants for the audio converter control block
package adac_pkg;
    // ==========================================================
    // widths and depths
    localparam int SAMPLE_W   = 16;   // sample word width
    localparam int QUEUE_DEP  = 4;    // entries per channel queue
    localparam int DIV_W      = 7;    // clock divisor field width
    localparam int OSR_W      = 8;    // log2 of oversampling ratio
    localparam int OSR        = 256;  // converter cycles per sample
    localparam int CHANNELS   = 2;    // left and right
    // ==========================================================
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_CON   = 8'h00;  // converter_control
    localparam logic [7:0] ADDR_STAT  = 8'h04;  // queue status and irq kind
    localparam logic [7:0] ADDR_DFLT  = 8'h08;  // fallback_value
    localparam logic [7:0] ADDR_LDAT  = 8'h0c;  // left_sample_port
    localparam logic [7:0] ADDR_RDAT  = 8'h10;  // right_sample_port
    // ==========================================================
    // converter_control fields
    localparam int CON_ON_BIT   = 15;  // converter_on
    localparam int CON_IDLE_BIT = 13;  // idle_halt
    localparam int CON_AMP_BIT  = 12;  // amp_keep
    localparam int CON_SIGN_BIT = 8;   // sign_select
    localparam int CON_DIV_LSB  = 0;   // clk_divisor low bit
    localparam logic [15:0] CON_WMASK = 16'hb17f;  // implemented bits
    localparam logic [15:0] CON_RESET = 16'h0005;  // divide by six
    // ==========================================================
    // status register fields, left in the high byte, right in the low
    localparam int STAT_LKIND_BIT  = 10;
    localparam int STAT_LEFT_QUEUE_FULL_BIT  = 9;
    localparam int STAT_LEFT_QUEUE_EMPTY_BIT = 8;
    localparam int STAT_RKIND_BIT  = 2;
    localparam int STAT_RIGHT_QUEUE_FULL_BIT  = 1;
    localparam int STAT_RIGHT_QUEUE_EMPTY_BIT = 0;
    localparam logic [15:0] STAT_WMASK = 16'h0404;  // only kind bits write
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [15:0] DFLT_RESET = 16'h0000;
    // ==========================================================
    // modulator feedback levels
    localparam logic signed [15:0] FB_POS = 16'sh7fff;
    localparam logic signed [15:0] FB_NEG = -16'sh7fff;
endpackage

// ### rtl/adac_queue.sv
// per-channel sample queue of fixed depth
`timescale 1ns/1ps
`default_nettype none
module adac_queue #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             push_i,   // write request
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic             pop_i,    // take head
    output logic      [WIDTH-1:0] head_o,   // oldest entry
    output logic                  full_o,
    output logic                  empty_o
);
    localparam int AW = $clog2(DEPTH);
    // ==========================================================
    // storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];       // entries
    logic [AW-1:0]    wr_ptr, next_wr_ptr;
    logic [AW-1:0]    rd_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count; // fill level
    logic             do_push, do_pop;

    // a push into a full queue is dropped, contents stay
    assign do_push = push_i && (count < (AW+1)'(DEPTH));
    assign do_pop  = pop_i && (count != '0);
    assign head_o  = mem[rd_ptr];
    assign full_o  = (count == (AW+1)'(DEPTH));
    assign empty_o = (count == '0);

    // next pointer and level values
    always_comb begin
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    // register pointers; entries need no reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
        if (do_push) begin
            mem[wr_ptr] <= data_i;
        end
    end
endmodule
`default_nettype wire

// ### rtl/adac_mod.sv
// per-channel 256x linear interpolator and second-order modulator
`timescale 1ns/1ps
`default_nettype none
module adac_mod #(
    parameter int OSR_W = 8
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               tick_i,    // converter clock enable
    input  wire logic               load_i,    // new sample this tick
    input  wire logic signed [15:0] sample_i,  // signed sample
    output logic                    bit_o      // one-bit stream
);
    // ==========================================================
    // interpolator state: value with OSR_W fraction bits
    localparam int AW = 16 + OSR_W;
    logic signed [AW-1:0] acc, next_acc;      // interpolated value
    logic signed [16:0]   step, next_step;    // per-tick increment
    // modulator integrators
    logic signed [19:0]   int1, next_int1;
    logic signed [23:0]   int2, next_int2;
    logic signed [24:0]   sum2;               // second sum before clipping
    logic                 next_bit;
    logic signed [15:0]   x;                  // modulator input
    logic signed [15:0]   fb;                 // fed back level

    assign x  = acc[AW-1:OSR_W];
    assign fb = bit_o ? adac_pkg::FB_POS : adac_pkg::FB_NEG;
    // second stage takes twice the fed back level, as a stable double loop needs
    assign sum2 = 25'(int2) + 25'(int1) - 25'(fb) - 25'(fb);

    // next values; the step is chosen so 256 ticks land exactly on target
    always_comb begin
        next_acc  = acc;
        next_step = step;
        next_int1 = int1;
        next_int2 = int2;
        next_bit  = bit_o;
        if (tick_i) begin
            if (load_i) begin
                next_step = 17'(sample_i) - 17'(x);
            end
            // the new step applies from the load tick itself, so 256 adds land on target
            next_acc  = acc + AW'(next_step);
            // second-order loop: two integrators, one-bit quantiser
            next_int1 = int1 + 20'(x) - 20'(fb);
            // clip, not wrap: a full-scale input must not flip the quantiser
            next_int2 = (sum2[24] != sum2[23]) ? (sum2[24] ? 24'sh800000 : 24'sh7fffff) : sum2[23:0];
            next_bit  = ~next_int2[23];
        end
    end

    // register state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc   <= '0;
            step  <= '0;
            int1  <= '0;
            int2  <= '0;
            bit_o <= 1'b0;
        end else begin
            acc   <= next_acc;
            step  <= next_step;
            int1  <= next_int1;
            int2  <= next_int2;
            bit_o <= next_bit;
        end
    end
endmodule
`default_nettype wire

// ### bench/adac_checker.sv
// assertion checker for the audio converter control block
`timescale 1ns/1ps
`default_nettype none
module adac_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        sys_idle_i,
    input wire logic        sys_sleep_i,
    input wire logic        left_bit_o,
    input wire logic        right_bit_o,
    input wire logic        amp_on_o,
    input wire logic        left_irq_o,
    input wire logic        right_irq_o
);
    // ==========
    // control shadow, updated at the edge where the write is acknowledged
    logic [15:0] ctl_sh;
    logic [15:0] next_ctl_sh;
    logic [15:0] lane;    // bits a write may change
    logic        stp;     // stopped by sleep, or by idle with halt set
    logic        rd_ack;  // a read answer is on the bus
    assign lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & adac_pkg::CON_WMASK;
    assign stp = sys_sleep_i | (ctl_sh[13] & sys_idle_i);
    assign rd_ack = wb_ack_o & ~wb_we_i;
    // next shadow value
    always_comb begin
        next_ctl_sh = ctl_sh;
        if (wb_ack_o && wb_we_i && wb_adr_i == adac_pkg::ADDR_CON) begin
            next_ctl_sh = (ctl_sh & ~lane) | (wb_dat_i[15:0] & lane);
        end
    end
    // register only
    always_ff @(posedge clk_i) begin
        ctl_sh <= rst_i ? adac_pkg::CON_RESET : next_ctl_sh;
    end
    // ==========
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_steady; ($stable(ctl_sh) && $stable(stp))[*2]; endsequence
    sequence s_stop; (ctl_sh[15] && stp && $stable(ctl_sh))[*2]; endsequence
    property p_ack; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_con; rd_ack && wb_adr_i == adac_pkg::ADDR_CON |-> wb_dat_o == {16'h0000, ctl_sh}; endproperty
    a_con: assert property (p_con) else $error("control readback");
    property p_unimp; rd_ack && wb_adr_i == adac_pkg::ADDR_CON |-> (wb_dat_o[15:0] & 16'h4e80) == 16'h0000; endproperty
    a_unimp: assert property (p_unimp) else $error("unused bits set");
    property p_stat; rd_ack && wb_adr_i == adac_pkg::ADDR_STAT |-> !(wb_dat_o[9] && wb_dat_o[8]) && !(wb_dat_o[1] && wb_dat_o[0]); endproperty
    a_stat: assert property (p_stat) else $error("full and empty together");
    property p_irq; rd_ack && wb_adr_i == adac_pkg::ADDR_STAT |-> left_irq_o == (wb_dat_o[10] ? wb_dat_o[8] : !wb_dat_o[9])
        && right_irq_o == (wb_dat_o[2] ? wb_dat_o[0] : !wb_dat_o[1]); endproperty
    a_irq: assert property (p_irq) else $error("irq level");
    property p_amp; s_steady |-> amp_on_o == (ctl_sh[15] && (!stp || ctl_sh[12])); endproperty
    a_amp: assert property (p_amp) else $error("amplifier enable");
    property p_freeze; s_stop ##1 (ctl_sh[15] && stp) |-> $stable(left_bit_o) && $stable(right_bit_o); endproperty
    a_freeze: assert property (p_freeze) else $error("stream moved while stopped");
    property p_div; ($changed(left_bit_o) || $changed(right_bit_o)) && ctl_sh[15] && !stp && ctl_sh[6:0] == 7'h03
        |=> !$stable(ctl_sh) || ($stable(left_bit_o) && $stable(right_bit_o)); endproperty
    a_div: assert property (p_div) else $error("stream faster than divided clock");
endmodule
bind adac_top adac_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .sys_idle_i, .sys_sleep_i, .left_bit_o, .right_bit_o, .amp_on_o, .left_irq_o, .right_irq_o);
`default_nettype wire

// ### bench/adac_cpu.sv
// bus master model standing for the processor that feeds samples
`timescale 1ns/1ps
`default_nettype none
module adac_cpu (
    input  wire logic        clk_i,
    input  wire logic        wb_ack_o,
    output logic             wb_cyc_i,
    output logic             wb_stb_i,
    output logic             wb_we_i,
    output logic [7:0]       wb_adr_i,
    output logic [3:0]       wb_sel_i,
    output logic [31:0]      wb_dat_i
);
    int gap;  // idle cycles after a transfer, so slow and prompt feeding both occur
    initial begin
        gap = 0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
    end
    // ==========
    // one classic cycle, held until ack is seen at a rising edge
    task automatic xfer(input logic we, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // released lines must not look like the last request
        wb_adr_i <= ~a;
        wb_dat_i <= ~{16'h0000, d};
        repeat (gap) @(posedge clk_i);
    endtask
    // ==========
    // start up: safe fallback first, converter clock kept in range
    task automatic start(input logic [15:0] ctl, input logic [15:0] dflt);
        xfer(1'b1, adac_pkg::ADDR_DFLT, dflt);
        if (ctl[6:0] < 7'h03) ctl[6:0] = 7'h03;
        xfer(1'b1, adac_pkg::ADDR_CON, ctl);
    endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the audio converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i, rst_i, sys_idle_i, sys_sleep_i;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        left_bit_o, right_bit_o, amp_on_o, left_irq_o, right_irq_o;
    int          fails, n_checks, cyc;
    logic [31:0] exp_q[$];  // expected read data, oldest first
    // {amp expected, idle, sleep, control}
    logic [18:0] pwr_tab[7] = '{19'h4_8003, 19'h2_a003, 19'h6_b003, 19'h6_8003, 19'h1_8003, 19'h5_9003, 19'h1_1003};
    adac_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .sys_idle_i, .sys_sleep_i, .left_bit_o, .right_bit_o, .amp_on_o, .left_irq_o, .right_irq_o);
    adac_cpu cpu (.clk_i, .wb_ack_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i);
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ==========
    // helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cpu.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        cpu.xfer(1'b0, a, 16'h0000);
    endtask
    // settle, then count ones on both streams; full scale is near all ones or all zeros
    task automatic dens(input logic hi);
        int l;
        int r;
        l = 0;
        r = 0;
        repeat (2200) @(posedge clk_i);
        repeat (512) begin
            @(negedge clk_i);
            l += int'(left_bit_o === 1'b1);
            r += int'(right_bit_o === 1'b1);
        end
        check("left density", 32'(hi ? l > 400 : l < 112), 32'h1);
        check("right density", 32'(hi ? r > 400 : r < 112), 32'h1);
    endtask
    // ==========
    // read answers are compared with the oldest note in mid-cycle
    always @(negedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            check("read data", wb_dat_o, exp_q.pop_front());
        end
    end
    // hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    // ==========
    // main sequence
    initial begin
        rst_i = 1'b1;
        sys_idle_i = 1'b0;
        sys_sleep_i = 1'b0;
        void'($urandom(89));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(adac_pkg::ADDR_CON, 16'h0005);
        rd(adac_pkg::ADDR_STAT, 16'h0101);
        rd(adac_pkg::ADDR_DFLT, 16'h0000);
        wr(adac_pkg::ADDR_CON, 16'hffff);
        rd(adac_pkg::ADDR_CON, 16'hb17f);
        wr(adac_pkg::ADDR_CON, 16'h0005);
        rd(8'h20, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            cpu.gap = $urandom_range(2);
            wr(adac_pkg::ADDR_LDAT, 16'($urandom));
            rd(adac_pkg::ADDR_STAT, (i < 3) ? 16'h0001 : 16'h0201);
        end
        rd(adac_pkg::ADDR_LDAT, 16'h0000);
        check("left irq", {31'h0, left_irq_o}, 32'h0);
        check("right irq", {31'h0, right_irq_o}, 32'h1);
        wr(adac_pkg::ADDR_STAT, 16'h0404);
        wr(adac_pkg::ADDR_RDAT, 16'($urandom));
        rd(adac_pkg::ADDR_STAT, 16'h0604);
        check("right irq", {31'h0, right_irq_o}, 32'h0);
        // four left entries drain one per 256 divided ticks
        cpu.gap = 0;
        cpu.start(16'h8003, 16'hffff);
        repeat (3000) @(posedge clk_i);
        rd(adac_pkg::ADDR_STAT, 16'h0405);
        repeat (120) @(posedge clk_i);
        rd(adac_pkg::ADDR_STAT, 16'h0505);
        check("left irq", {31'h0, left_irq_o}, 32'h1);
        dens(1'b1);
        cpu.start(16'h8103, 16'h8000);
        dens(1'b0);
        cpu.start(16'h8103, 16'h7fff);
        dens(1'b1);
        cpu.start(16'h8003, 16'h0000);
        dens(1'b0);
        foreach (pwr_tab[k]) begin
            @(posedge clk_i);
            sys_idle_i <= pwr_tab[k][17];
            sys_sleep_i <= pwr_tab[k][16];
            wr(adac_pkg::ADDR_CON, pwr_tab[k][15:0]);
            repeat (3) @(negedge clk_i);
            check("amp enable", {31'h0, amp_on_o}, {31'h0, pwr_tab[k][18]});
        end
        finish_test();
    end
endmodule
`default_nettype wire
